// [core/vsim_map.svh]
// Purpose: register offsets, field positions and reset values
// Assumes: 32-bit AHB-Lite word registers
// Notes:   offsets are byte addresses
`ifndef VSIM_MAP_SVH
`define VSIM_MAP_SVH
// register byte offsets (12-bit decode)
`define VSIM_OFF_PCI_CMD   12'hF04
`define VSIM_OFF_LIRQ_STAT 12'hF08
`define VSIM_OFF_S2_TO     12'hF34
`define VSIM_OFF_S3_CTL    12'hF3C
`define VSIM_OFF_S3_BS     12'hF40
`define VSIM_OFF_S3_BD     12'hF44
`define VSIM_OFF_S3_TO     12'hF48
`define VSIM_OFF_LW_CTL    12'hF64
`define VSIM_OFF_LW_BS     12'hF68
// control field positions
`define VSIM_B_EN      31
`define VSIM_B_POSTED_WRITE_ENABLE    30
`define VSIM_B_PREFETCH_READ_ENABLE    29
`define VSIM_F_PGM_HI  23
`define VSIM_F_PGM_LO  22
`define VSIM_F_SUP_HI  21
`define VSIM_F_SUP_LO  20
`define VSIM_F_VAS_HI  18
`define VSIM_F_VAS_LO  16
`define VSIM_B_W64     7
`define VSIM_B_LOCK    6
`define VSIM_F_LAS_HI  1
`define VSIM_F_LAS_LO  0
`define VSIM_B_BME     2
// reset values
`define VSIM_RST_SEL   2'h3
`define VSIM_RST_ZERO  32'h0000_0000
// space codes
`define VSIM_VAS_A16   3'h0
`define VSIM_VAS_A24   3'h1
`define VSIM_VAS_A32   3'h2
`define VSIM_VAS_USR1  3'h6
`define VSIM_VAS_USR2  3'h7
`define VSIM_LAS_MEM   2'h0
`define VSIM_LAS_RSVD  2'h3
`endif

// [core/vsim_pkg.sv]
// Purpose: shared types of the inbound window block
// Assumes: constants live in vsim_map.svh
// Notes:   none
package vsim_pkg;
  // decoded window control fields
  typedef struct packed {
    logic       en;
    logic       posted_write_enable;
    logic       prefetch_read_enable;
    logic [1:0] program_data_am_select;
    logic [1:0] sup;
    logic [2:0] vme_space_select;
    logic       w64;
    logic       lock;
    logic [1:0] pci_space_select;
  } vsim_ctl_t;
  // request handed to the pci master datapath
  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [1:0]  space;
    logic        posted;
    logic        prefetch;
    logic        wide64;
    logic        lock;
  } vsim_pci_req_t;
  typedef enum logic [1:0] {
    VSIM_IDLE,
    VSIM_WAIT,
    VSIM_ACK
  } vsim_state_t;
endpackage

// [core/vsim_top.sv]
// Purpose: inbound vme slave window 3 and location watch decode
// Assumes: vme pins are asynchronous, pci side on clk
// Notes:   registers on an ahb-lite slave, zero wait states
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ns
`include "vsim_map.svh"
// Functional notes
// - images claim cycles only when enabled
// - slave image needs pci bus master enable
// - only memory-space writes may be posted
// - posted write enable selects posting
// - prefetch read enable selects prefetching
// - program/data select filters address modifiers
// - privilege select filters address modifiers
// - window 3 space select decode
// - wide pci enable allows 64-bit transfers
// - rmw lock enable holds pci lock
// - pci space select routes cycles
// - base, bound, offset hold bits 31:16
// - hit when base <= addr < bound
// - location watch is one 4k window
// - location watch takes reads and writes
// - no block transfers to location watch
// - address bits 4:3 pick status flag
// - own master cycles still get acknowledge
// - location watch stores no data
// - location watch space select decode
module vsim_top (
  input  wire logic                   clk,             // 10 MHz clock
  input  wire logic                   reset_n,         // async reset
  input  wire logic                   hsel,            // ahb select
  input  wire logic [31:0]            haddr,           // ahb address
  input  wire logic [1:0]             htrans,          // ahb transfer type
  input  wire logic                   hwrite,          // ahb write
  input  wire logic [2:0]             hsize,           // ahb size
  input  wire logic [31:0]            hwdata,          // ahb write data
  input  wire logic                   hready,          // ahb ready in
  output logic      [31:0]            hrdata,          // ahb read data
  output logic                        hreadyout,       // ahb ready out
  output logic                        hresp,           // ahb response
  input  wire logic                   vme_as_n,        // vme address strobe
  input  wire logic [31:0]            vme_addr,        // vme address
  input  wire logic [5:0]             vme_am,          // vme address modifier
  input  wire logic                   vme_write_n,     // vme write low
  input  wire logic                   vme_rmw,         // vme rmw in progress
  output logic                        vme_dtack_o,     // dtack level driven
  output logic                        vme_dtack_oe_n,  // dtack drive, low on
  output vsim_pkg::vsim_pci_req_t     pci_req,         // pci request fields
  output logic                        pci_req_valid,   // request pulse
  output logic                        pci_lock,        // pci bus lock
  input  wire logic                   pci_done,        // pci cycle finished
  output logic [3:0]                  local_irq_status // location flags
);

  // registers
  logic [15:0]         s2_to_q;     // window 2 offset bits 31:16
  vsim_pkg::vsim_ctl_t s3_ctl_q;    // window 3 control
  logic [15:0]         s3_bs_q;     // window 3 base
  logic [15:0]         s3_bd_q;     // window 3 bound
  logic [15:0]         s3_to_q;     // window 3 offset
  vsim_pkg::vsim_ctl_t lw_ctl_q;    // location watch control
  logic [19:0]         lw_bs_q;     // location watch base 31:12
  logic                bme_q;       // pci bus master enable
  logic [3:0]          lirq_q;      // location watch status flags
  // ahb data phase capture
  logic                wr_pend_q;   // write waiting for data
  logic [11:0]         wr_addr_q;   // captured write offset
  logic [31:0]         rdata_q;     // read data register
  // vme pin synchronisers
  logic [1:0]          as_sync_q;   // strobe sync chain
  logic                as_q;        // strobe delayed for edge
  logic [31:0]         addr_m_q;    // address sync stage 1
  logic [31:0]         addr_s_q;    // address sync stage 2
  logic [5:0]          am_m_q;      // modifier stage 1
  logic [5:0]          am_s_q;      // modifier stage 2
  logic [1:0]          wr_sync_q;   // write_n chain
  logic [1:0]          rmw_sync_q;  // rmw chain
  // slave state
  vsim_pkg::vsim_state_t   st_q;    // slave cycle state
  vsim_pkg::vsim_pci_req_t req_q;   // request to pci side
  logic                    req_v_q; // request pulse
  logic                    lock_q;  // pci lock held
  logic                    oe_n_q;  // dtack drive
  logic                    flag_hit; // location hit this cycle

  // control word packing for reads
  function automatic logic [31:0] ctl_word(input vsim_pkg::vsim_ctl_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`VSIM_B_EN] = c.en;
    w[`VSIM_B_POSTED_WRITE_ENABLE] = c.posted_write_enable;
    w[`VSIM_B_PREFETCH_READ_ENABLE] = c.prefetch_read_enable;
    w[`VSIM_F_PGM_HI:`VSIM_F_PGM_LO] = c.program_data_am_select;
    w[`VSIM_F_SUP_HI:`VSIM_F_SUP_LO] = c.sup;
    w[`VSIM_F_VAS_HI:`VSIM_F_VAS_LO] = c.vme_space_select;
    w[`VSIM_B_W64] = c.w64;
    w[`VSIM_B_LOCK] = c.lock;
    w[`VSIM_F_LAS_HI:`VSIM_F_LAS_LO] = c.pci_space_select;
    return w;
  endfunction

  // address modifier check against one window's selections
  function automatic logic am_ok(input vsim_pkg::vsim_ctl_t c, input logic [5:0] am,
                                 input logic lm);
    logic sp;
    logic single;
    logic pg;
    logic sv;
    sp = 1'b0;
    single = (am[1:0] == 2'h1) || (am[1:0] == 2'h2);
    case (c.vme_space_select)
      `VSIM_VAS_A16:  sp = lm && (am[5:3] == 3'h5);
      `VSIM_VAS_A24:  sp = (am[5:3] == 3'h7);
      `VSIM_VAS_A32:  sp = (am[5:3] == 3'h1);
      `VSIM_VAS_USR1: sp = (am[5:3] == 3'h2);
      `VSIM_VAS_USR2: sp = (am[5:3] == 3'h3);
      default:        sp = 1'b0; // reserved codes claim nothing
    endcase
    // user spaces carry no program or privilege coding
    if (am[5:4] == 2'h1) begin
      return sp;
    end
    // a16 codes are data only; others must be single cycles
    if (am[5:3] == 3'h5) begin
      single = (am[1:0] == 2'h1);
    end
    pg = (am[1:0] == 2'h2) ? c.program_data_am_select[1] : c.program_data_am_select[0];
    sv = am[2] ? c.sup[1] : c.sup[0];
    // block and multiplexed block codes are never claimed here
    return sp && single && pg && sv;
  endfunction

  // decoded hits, combinational from synchronised pins
  logic        as_fall;   // strobe asserted edge
  logic        s3_hit;    // window 3 decode
  logic        lw_hit;    // location watch decode
  logic        vme_wr;    // write cycle
  logic        post_ok;   // write may be posted
  assign as_fall = as_q && !as_sync_q[1];
  assign vme_wr  = !wr_sync_q[1];
  assign s3_hit  = s3_ctl_q.en && bme_q
                   && (s3_ctl_q.pci_space_select != `VSIM_LAS_RSVD)
                   && (addr_s_q[31:16] >= s3_bs_q)
                   && (addr_s_q[31:16] < s3_bd_q)
                   && am_ok(s3_ctl_q, am_s_q, 1'b0);
  // bus master enable does not gate the watch; it never reaches pci
  assign lw_hit  = lw_ctl_q.en
                   && (addr_s_q[31:12] == lw_bs_q)
                   && am_ok(lw_ctl_q, am_s_q, 1'b1);
  assign post_ok = vme_wr && s3_ctl_q.posted_write_enable
                   && (s3_ctl_q.pci_space_select == `VSIM_LAS_MEM);
  assign flag_hit = (st_q == vsim_pkg::VSIM_IDLE) && as_fall && lw_hit;

  // pin synchronisers: logic reads the second stage, plus as_q for the strobe edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      as_sync_q  <= 2'h3;
      as_q       <= 1'b1;
      addr_m_q   <= 32'h0000_0000;
      addr_s_q   <= 32'h0000_0000;
      am_m_q     <= 6'h00;
      am_s_q     <= 6'h00;
      wr_sync_q  <= 2'h3;
      rmw_sync_q <= 2'h0;
    end else begin
      as_sync_q  <= {as_sync_q[0], vme_as_n};
      as_q       <= as_sync_q[1];
      addr_m_q   <= vme_addr;
      addr_s_q   <= addr_m_q;
      am_m_q     <= vme_am;
      am_s_q     <= am_m_q;
      wr_sync_q  <= {wr_sync_q[0], vme_write_n};
      rmw_sync_q <= {rmw_sync_q[0], vme_rmw};
    end
  end

  // ahb address phase: capture writes, register read data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rdata_q   <= 32'h0000_0000;
    end else begin
      wr_pend_q <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        wr_addr_q <= haddr[11:0];
        if (!hwrite) begin
          // unmapped offsets read as zero, reserved bits as zero
          case (haddr[11:0])
            `VSIM_OFF_PCI_CMD:   rdata_q <= {29'h0, bme_q, 2'h0};
            `VSIM_OFF_LIRQ_STAT: rdata_q <= {28'h0, lirq_q};
            `VSIM_OFF_S2_TO:     rdata_q <= {s2_to_q, 16'h0000};
            `VSIM_OFF_S3_CTL:    rdata_q <= ctl_word(s3_ctl_q);
            `VSIM_OFF_S3_BS:     rdata_q <= {s3_bs_q, 16'h0000};
            `VSIM_OFF_S3_BD:     rdata_q <= {s3_bd_q, 16'h0000};
            `VSIM_OFF_S3_TO:     rdata_q <= {s3_to_q, 16'h0000};
            `VSIM_OFF_LW_CTL:    rdata_q <= ctl_word(lw_ctl_q) & 32'h80F7_0000;
            `VSIM_OFF_LW_BS:     rdata_q <= {lw_bs_q, 12'h000};
            default:             rdata_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // register writes in the data phase; hsize is ignored, words only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bme_q    <= 1'b0;
      s2_to_q  <= 16'h0000;
      s3_bs_q  <= 16'h0000;
      s3_bd_q  <= 16'h0000;
      s3_to_q  <= 16'h0000;
      lw_bs_q  <= 20'h00000;
      s3_ctl_q <= '{program_data_am_select: `VSIM_RST_SEL, sup: `VSIM_RST_SEL, default: '0};
      lw_ctl_q <= '{program_data_am_select: `VSIM_RST_SEL, sup: `VSIM_RST_SEL, default: '0};
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `VSIM_OFF_PCI_CMD: bme_q   <= hwdata[`VSIM_B_BME];
        `VSIM_OFF_S2_TO:   s2_to_q <= hwdata[31:16];
        `VSIM_OFF_S3_BS:   s3_bs_q <= hwdata[31:16];
        `VSIM_OFF_S3_BD:   s3_bd_q <= hwdata[31:16];
        `VSIM_OFF_S3_TO:   s3_to_q <= hwdata[31:16];
        `VSIM_OFF_LW_BS:   lw_bs_q <= hwdata[31:12];
        `VSIM_OFF_S3_CTL: begin
          s3_ctl_q.en   <= hwdata[`VSIM_B_EN];
          s3_ctl_q.posted_write_enable <= hwdata[`VSIM_B_POSTED_WRITE_ENABLE];
          s3_ctl_q.prefetch_read_enable <= hwdata[`VSIM_B_PREFETCH_READ_ENABLE];
          s3_ctl_q.program_data_am_select  <= hwdata[`VSIM_F_PGM_HI:`VSIM_F_PGM_LO];
          s3_ctl_q.sup  <= hwdata[`VSIM_F_SUP_HI:`VSIM_F_SUP_LO];
          s3_ctl_q.vme_space_select  <= hwdata[`VSIM_F_VAS_HI:`VSIM_F_VAS_LO];
          s3_ctl_q.w64  <= hwdata[`VSIM_B_W64];
          s3_ctl_q.lock <= hwdata[`VSIM_B_LOCK];
          s3_ctl_q.pci_space_select  <= hwdata[`VSIM_F_LAS_HI:`VSIM_F_LAS_LO];
        end
        `VSIM_OFF_LW_CTL: begin
          // the watch has no pci controls; those fields stay zero
          lw_ctl_q.en  <= hwdata[`VSIM_B_EN];
          lw_ctl_q.program_data_am_select <= hwdata[`VSIM_F_PGM_HI:`VSIM_F_PGM_LO];
          lw_ctl_q.sup <= hwdata[`VSIM_F_SUP_HI:`VSIM_F_SUP_LO];
          lw_ctl_q.vme_space_select <= hwdata[`VSIM_F_VAS_HI:`VSIM_F_VAS_LO];
        end
        default: ;
      endcase
    end
  end

  // location watch flags: write one to clear, a new hit wins the clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lirq_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (flag_hit && (addr_s_q[4:3] == i[1:0])) begin
          lirq_q[i] <= 1'b1;
        end else if (wr_pend_q && (wr_addr_q == `VSIM_OFF_LIRQ_STAT) && hwdata[i]) begin
          lirq_q[i] <= 1'b0;
        end
      end
    end
  end

  // slave cycle sequencing; the watch needs no data path at all
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q    <= vsim_pkg::VSIM_IDLE;
      req_q   <= '0;
      req_v_q <= 1'b0;
      lock_q  <= 1'b0;
      oe_n_q  <= 1'b1;
    end else begin
      req_v_q <= 1'b0;
      case (st_q)
        vsim_pkg::VSIM_IDLE: begin
          if (as_fall && lw_hit) begin
            // acked even when our own master ran the cycle
            oe_n_q <= 1'b0;
            st_q   <= vsim_pkg::VSIM_ACK;
          end else if (as_fall && s3_hit) begin
            req_q.addr     <= addr_s_q + {s3_to_q, 16'h0000};
            req_q.write    <= vme_wr;
            req_q.space    <= s3_ctl_q.pci_space_select;
            req_q.posted   <= post_ok;
            req_q.prefetch <= !vme_wr && s3_ctl_q.prefetch_read_enable;
            req_q.wide64   <= s3_ctl_q.w64;
            req_q.lock     <= rmw_sync_q[1] && s3_ctl_q.lock;
            lock_q         <= rmw_sync_q[1] && s3_ctl_q.lock;
            req_v_q        <= 1'b1;
            if (post_ok) begin
              // posted: vme side ends now, pci completes later
              oe_n_q <= 1'b0;
              st_q   <= vsim_pkg::VSIM_ACK;
            end else begin
              st_q <= vsim_pkg::VSIM_WAIT;
            end
          end
        end
        vsim_pkg::VSIM_WAIT: begin
          if (pci_done) begin
            oe_n_q <= 1'b0;
            st_q   <= vsim_pkg::VSIM_ACK;
          end
        end
        vsim_pkg::VSIM_ACK: begin
          // release on strobe; lock also ends when the strobe rises, rmw is not checked
          if (as_sync_q[1]) begin
            oe_n_q <= 1'b1;
            lock_q <= 1'b0;
            st_q   <= vsim_pkg::VSIM_IDLE;
          end
        end
        default: st_q <= vsim_pkg::VSIM_IDLE;
      endcase
    end
  end

  // outputs straight from flip-flops; hreadyout, hresp and vme_dtack_o are tied constants
  assign hrdata           = rdata_q;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign vme_dtack_o      = 1'b0;
  assign vme_dtack_oe_n   = oe_n_q;
  assign pci_req          = req_q;
  assign pci_req_valid    = req_v_q;
  assign pci_lock         = lock_q;
  assign local_irq_status = lirq_q;

endmodule

// [dv/vsim_asserts.sv]
// Purpose: port-level checks of the inbound window and location watch
// Assumes: single clock domain, async active-low reset
// Notes:   strobe is synchronised inside, so ack timing is loose by a cycle
`timescale 1ns/1ns
module vsim_asserts (
  input wire logic                    clk,             // block clock
  input wire logic                    reset_n,         // async reset
  input wire logic                    vme_as_n,        // strobe pin
  input wire logic                    vme_dtack_oe_n,  // dtack drive, low on
  input wire vsim_pkg::vsim_pci_req_t pci_req,         // request fields
  input wire logic                    pci_req_valid,   // request pulse
  input wire logic                    pci_lock,        // pci bus lock
  input wire logic [3:0]              local_irq_status // watch flags
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // an acknowledge only answers a strobe held through the synchroniser
  a_ack_needs_strobe: assert property (
    $fell(vme_dtack_oe_n) |-> !vme_as_n && $past(vme_as_n, 2) == 1'b0)
    else $error("acknowledge without a held strobe");
  // a long-released strobe must have dropped the acknowledge
  a_ack_release: assert property (
    vme_as_n [*5] |-> vme_dtack_oe_n)
    else $error("acknowledge outlives the strobe");
  a_post_memory: assert property (
    pci_req_valid && pci_req.posted |-> pci_req.write && pci_req.space == 2'h0)
    else $error("posted request is not a memory write");
  // posted writes end the vme cycle at once, others wait for the pci side
  a_post_ack: assert property (
    pci_req_valid && pci_req.posted |-> !vme_dtack_oe_n)
    else $error("posted write not acknowledged with its request");
  a_nonpost_wait: assert property (
    pci_req_valid && !pci_req.posted |-> vme_dtack_oe_n)
    else $error("unposted cycle acknowledged before pci completes");
  a_space_legal: assert property (
    pci_req_valid |-> pci_req.space != 2'h3)
    else $error("request to reserved pci space");
  a_prefetch_read: assert property (
    pci_req_valid && pci_req.prefetch |-> !pci_req.write)
    else $error("prefetch flagged on a write");
  a_lock_cause: assert property (
    $rose(pci_lock) |-> pci_req.lock && !vme_as_n)
    else $error("pci lock without a locked request");
  a_lock_drop: assert property (
    vme_as_n [*5] |-> !pci_lock)
    else $error("pci lock held after the cycle");
  // a hit names exactly one flag, so no two flags rise together
  a_flag_single: assert property (
    $countones(local_irq_status & ~$past(local_irq_status)) <= 1)
    else $error("several watch flags set at once");
endmodule

bind vsim_top vsim_asserts i_chk (
  .clk(clk), .reset_n(reset_n), .vme_as_n(vme_as_n), .vme_dtack_oe_n(vme_dtack_oe_n),
  .pci_req(pci_req), .pci_req_valid(pci_req_valid), .pci_lock(pci_lock),
  .local_irq_status(local_irq_status)
);

// [dv/vsim_vme_master.sv]
// Purpose: vme master issuing single slave cycles
// Assumes: acknowledge line is pulled up when not driven
// Notes:   released lines show the inverse of the last value, except rmw, which returns low
`timescale 1ns/1ns
module vsim_vme_master (
  input  wire logic        clk,     // bench clock
  input  wire logic        dtack_n, // resolved acknowledge line
  output logic             as_n,    // address strobe
  output logic [31:0]      addr,    // address lines
  output logic [5:0]       am,      // address modifier
  output logic             write_n, // low for write
  output logic             rmw      // read-modify-write
);
  // idle bus at time zero
  initial begin
    as_n = 1'b1;
    addr = 32'hFFFF_FFFF;
    am = 6'h3F;
    write_n = 1'b1;
    rmw = 1'b0;
  end

  // one cycle; the modifier is taken as given, block codes only on command
  task automatic cycle(input logic [31:0] a, input logic [5:0] m, input logic w,
                       input logic r, output logic ack);
    ack = 1'b0;
    addr <= a;
    am <= m;
    write_n <= !w;
    rmw <= r;
    @(posedge clk);
    as_n <= 1'b0; // address settled one edge before the strobe
    repeat (20) begin
      @(posedge clk);
      if (dtack_n === 1'b0) begin
        ack = 1'b1;
        break;
      end
    end
    // a silent slave means the cycle was refused
    as_n <= 1'b1;
    addr <= ~a;
    am <= ~m;
    write_n <= w;
    rmw <= 1'b0;
    repeat (8) begin
      @(posedge clk);
      if (dtack_n !== 1'b0) break;
    end
    repeat (4) @(posedge clk); // strobe high long enough to rearm
  endtask
endmodule

// [dv/tb_vme_slave_image_and_loc_monitor.sv]
// Purpose: self-checking bench of the inbound window and location watch
// Assumes: registers over ahb-lite, vme cycles from the master model
// Notes:   the window offset is chosen so the pci address wraps
`timescale 1ns/1ns
module tb_vme_slave_image_and_loc_monitor;
  localparam logic [11:0] W3_CTL = 12'hF3C, W3_LO = 12'hF40, W3_HI = 12'hF44;
  localparam logic [11:0] W3_XL = 12'hF48, LW_CTL = 12'hF64, LW_LO = 12'hF68;
  localparam logic [11:0] PCI_CMD = 12'hF04, FLAGS = 12'hF08;
  localparam logic [31:0] XLAT = 32'hFFF8_0000; // wraps past 2^32
  typedef struct packed {
    logic [31:0] ctl; // window 3 control
    logic [31:0] adr; // vme address
    logic [5:0]  am;  // address modifier
    logic [1:0]  op;  // write, rmw
    logic [4:0]  xf;  // claim, posted, prefetch, wide, lock
    logic [1:0]  sp;  // pci space
  } vsim_row_t;
  typedef struct packed {
    logic [11:0] off;  // byte offset
    logic [31:0] rst;  // reset value
    logic [31:0] ones; // read back after all ones written
  } vsim_reg_t;
  vsim_reg_t regs [8] = '{'{12'hF34, 32'h0, 32'hFFFF_0000},
    '{W3_CTL, 32'h00F0_0000, 32'hE0F7_00C3}, '{W3_LO, 32'h0, 32'hFFFF_0000},
    '{W3_HI, 32'h0, 32'hFFFF_0000}, '{W3_XL, 32'h0, 32'hFFFF_0000},
    '{LW_CTL, 32'h00F0_0000, 32'h80F7_0000}, '{LW_LO, 32'h0, 32'hFFFF_F000},
    '{12'hF00, 32'h0, 32'h0}};
  vsim_row_t rows [21] = '{
    '{32'h80F2_0000, 32'h0010_0000, 6'h09, 2'h0, 5'h10, 2'h0},
    '{32'h80F2_0000, 32'h0020_0000, 6'h09, 2'h0, 5'h00, 2'h0},
    '{32'h00F2_0000, 32'h0010_0000, 6'h09, 2'h0, 5'h00, 2'h0},
    '{32'hC0F2_0000, 32'h0010_0010, 6'h09, 2'h2, 5'h18, 2'h0},
    '{32'h80F2_0000, 32'h0010_0010, 6'h09, 2'h2, 5'h10, 2'h0},
    '{32'hC0F2_0001, 32'h0010_0010, 6'h09, 2'h2, 5'h10, 2'h1},
    '{32'h80F2_0002, 32'h0010_0020, 6'h09, 2'h0, 5'h10, 2'h2},
    '{32'h80F2_0003, 32'h0010_0020, 6'h09, 2'h0, 5'h00, 2'h0},
    '{32'hA0F2_0000, 32'h0010_0040, 6'h09, 2'h0, 5'h14, 2'h0},
    '{32'h80F2_0080, 32'h0010_0040, 6'h09, 2'h0, 5'h12, 2'h0},
    '{32'h80F2_0040, 32'h001F_FFFC, 6'h09, 2'h1, 5'h11, 2'h0},
    '{32'h80F2_0000, 32'h0010_0080, 6'h09, 2'h1, 5'h10, 2'h0},
    '{32'h8072_0000, 32'h0010_0000, 6'h0A, 2'h0, 5'h00, 2'h0},
    '{32'h80B2_0000, 32'h0010_0000, 6'h0A, 2'h0, 5'h10, 2'h0},
    '{32'h80D2_0000, 32'h0010_0000, 6'h0D, 2'h0, 5'h00, 2'h0},
    '{32'h80E2_0000, 32'h0010_0000, 6'h0D, 2'h0, 5'h10, 2'h0},
    '{32'h80F1_0000, 32'h0010_0000, 6'h39, 2'h0, 5'h10, 2'h0},
    '{32'h80F1_0000, 32'h0010_0000, 6'h09, 2'h0, 5'h00, 2'h0},
    '{32'h80F6_0000, 32'h0010_0000, 6'h10, 2'h0, 5'h10, 2'h0},
    '{32'h80F7_0000, 32'h0010_0000, 6'h18, 2'h0, 5'h10, 2'h0},
    '{32'h80F0_0000, 32'h0010_0000, 6'h29, 2'h0, 5'h00, 2'h0}};
  logic        clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, pci_done = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q; // bus address, data
  logic [1:0]  htrans = 2'h0; // idle until the first transfer
  logic [2:0]  hsize = 3'h2;  // whole words only
  logic        hreadyout, hresp, vme_dtack_o, vme_dtack_oe_n, pci_req_valid, pci_lock, ack;
  logic        vme_as_n, vme_write_n, vme_rmw; // master model outputs
  logic [31:0] vme_addr;     // vme address lines
  logic [5:0]  vme_am;       // vme modifier lines
  logic [3:0]  local_irq_status; // watch flags
  vsim_pkg::vsim_pci_req_t pci_req, cap; // live and captured request
  int          error_cnt = 0, check_count = 0, req_n = 0, n, wait_n = 0;
  wire         dtack_n = vme_dtack_oe_n ? 1'b1 : vme_dtack_o; // pulled up when released

  vsim_top i_dut (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .vme_as_n, .vme_addr, .vme_am,
    .vme_write_n, .vme_rmw, .vme_dtack_o, .vme_dtack_oe_n, .pci_req, .pci_req_valid,
    .pci_lock, .pci_done, .local_irq_status);
  vsim_vme_master i_vme (.clk, .dtack_n, .as_n(vme_as_n), .addr(vme_addr), .am(vme_am),
    .write_n(vme_write_n), .rmw(vme_rmw));

  always #50 clk = ~clk;
  // pci side: count requests, finish unposted ones after a short delay
  always @(posedge clk) begin
    pci_done <= (wait_n == 1); // one assignment per edge; a new request never meets a count of one
    if (pci_req_valid) begin
      req_n <= req_n + 1;
      cap <= pci_req;
    end
    if (pci_req_valid && !pci_req.posted) wait_n <= 3;
    else if (wait_n != 0) wait_n <= wait_n - 1;
  end
  // watchdog at over twenty times the expected run, so a hang still gets a verdict
  initial begin
    #2_000_000;
    error_cnt++;
    close_out;
  end

  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata; // read data taken at the closing edge
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected word at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic chk_b(input logic got, input logic want);
    check_count++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected bit at %0t: got %b want %b", $time, got, want);
    end
  endtask
  // reset values, then optionally the writable bits of each register
  task automatic reg_pass(input bit ones);
    foreach (regs[i]) begin
      ahb(1'b0, regs[i].off, 32'h0);
      chk_w(q, regs[i].rst);
      chk_b(hresp, 1'b0);
      if (ones) begin
        ahb(1'b1, regs[i].off, 32'hFFFF_FFFF);
        ahb(1'b0, regs[i].off, 32'h0);
        chk_w(q, regs[i].ones);
      end
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    reg_pass(1'b1);
    $display("test registers done");
    ahb(1'b1, PCI_CMD, 32'h4);
    ahb(1'b1, W3_LO, 32'h0010_0000);
    ahb(1'b1, W3_HI, 32'h0020_0000);
    ahb(1'b1, W3_XL, XLAT);
    foreach (rows[i]) begin
      ahb(1'b1, W3_CTL, rows[i].ctl);
      n = req_n;
      i_vme.cycle(rows[i].adr, rows[i].am, rows[i].op[1], rows[i].op[0], ack);
      chk_b(ack, rows[i].xf[4]);
      chk_b(pci_lock, 1'b0);
      chk_w(32'(req_n - n), {31'h0, rows[i].xf[4]});
      if (rows[i].xf[4]) begin
        chk_w(cap.addr, rows[i].adr + XLAT);
        chk_w({cap.write, cap.posted, cap.prefetch, cap.wide64, cap.lock, cap.space},
              {rows[i].op[1], rows[i].xf[3:0], rows[i].sp});
      end
    end
    $display("test window rows done");
    // master enable off: window refuses, location watch still answers
    ahb(1'b1, PCI_CMD, 32'h0);
    ahb(1'b1, W3_CTL, 32'h80F2_0000);
    n = req_n;
    i_vme.cycle(32'h0010_0000, 6'h09, 1'b0, 1'b0, ack);
    chk_b(ack, 1'b0);
    ahb(1'b1, LW_LO, 32'h0030_0000);
    ahb(1'b1, LW_CTL, 32'h80F2_0000);
    for (int k = 0; k < 4; k++) begin
      i_vme.cycle(32'h0030_0FE0 + 32'(k * 8), 6'h09, k[0], 1'b0, ack);
      chk_b(ack, 1'b1);
      chk_w(32'(local_irq_status), 32'((1 << (k + 1)) - 1));
    end
    chk_w(32'(req_n - n), 32'h0);
    i_vme.cycle(32'h0030_1000, 6'h09, 1'b0, 1'b0, ack);
    chk_b(ack, 1'b0);
    i_vme.cycle(32'h0030_0000, 6'h0B, 1'b0, 1'b0, ack);
    chk_b(ack, 1'b0);
    ahb(1'b1, FLAGS, 32'hF);
    ahb(1'b0, FLAGS, 32'h0);
    chk_w(q, 32'h0);
    ahb(1'b1, LW_LO, 32'h0000_F000);
    ahb(1'b1, LW_CTL, 32'h80F0_0000);
    i_vme.cycle(32'h0000_F018, 6'h29, 1'b1, 1'b0, ack);
    chk_w({27'h0, ack, local_irq_status}, 32'h18);
    $display("test location watch done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk_w(32'(local_irq_status), 32'h0);
    reg_pass(1'b0);
    $display("test second reset done");
    close_out;
  end
endmodule
